// [verilog/aspm_pkg.sv]
/*
 * Constants shared by the analog-shared pin multiplexer: register
 * offsets, reset values and the fixed pin/bit maps of the three groups.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
`default_nettype none

package aspm_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CMP_MODE_OFS = 8'h00;
	localparam logic [7:0] CMP_PUD_OFS  = 8'h04;
	localparam logic [7:0] CMP_DATA_OFS = 8'h08;
	localparam logic [7:0] CMP_DIR_OFS  = 8'h0c;
	localparam logic [7:0] AG1_SEL_OFS  = 8'h10;
	localparam logic [7:0] AG1_DATA_OFS = 8'h14;
	localparam logic [7:0] AG1_DIR_OFS  = 8'h18;
	localparam logic [7:0] AG2_SEL_OFS  = 8'h1c;
	localparam logic [7:0] AG2_DATA_OFS = 8'h20;
	localparam logic [7:0] AG2_DIR_OFS  = 8'h24;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	// mode 1 (reserved) on every pin: nothing driven, pin left analog
	localparam logic [15:0] CMP_MODE_RST = 16'h5555;
	localparam logic [7:0]  CMP_PUD_RST  = 8'h00;
	localparam logic [7:0]  CMP_DATA_RST = 8'h00;
	localparam logic [7:0]  CMP_DIR_RST  = 8'h00;
	// every odd select bit set: analog path
	localparam logic [31:0] AG_SEL_RST   = 32'hAAAA_AAAA;
	localparam logic [3:0]  AG_DATA_RST  = 4'h0;
	localparam logic [3:0]  AG_DIR_RST   = 4'h0;
	localparam logic [9:0]  AG_ANA_RST   = 10'h3FF;

	// ----------------------------------------------------------------
	// comparator-capable group: per-pin mode field and comparator map
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ASPM_MODE_GPIO = 2'b00,
		ASPM_MODE_RSV1 = 2'b01,
		ASPM_MODE_RSV2 = 2'b10,
		ASPM_MODE_CMP  = 2'b11
	} aspm_mode_e;

	// pins 0 and 6 (128, 134) have no comparator
	localparam logic [7:0]      CMP_PIN_VALID = 8'hBE;
	// comparator index (comparator n -> n-1), entry [i] for pin i
	localparam logic [7:0][2:0] CMP_PIN_SRC   = {
		3'h4, 3'h0, 3'h3, 3'h2, 3'h1, 3'h5, 3'h0, 3'h0
	};

	// ----------------------------------------------------------------
	// analog groups: pin index and select bit per digital bit
	// ----------------------------------------------------------------
	// pins: A0 A2 A3 A4 A6 A7 B0 B3 B4 B7 as indices 0..9
	localparam logic [3:0][3:0] ASD_PIN_IDX = {4'h8, 4'h4, 4'h3, 4'h1};
	localparam logic [3:0][4:0] ASD_SEL_BIT = {5'h19, 5'h0D, 5'h09, 5'h05};

endpackage : aspm_pkg

`default_nettype wire

// [verilog/aspm_aio_group.sv]
/*
 * One ten-pin analog group: four digital bits on four pins, the rest
 * analog only. Pin inputs are asynchronous and are synchronised here.
 * Assumes select, data and direction come from registers on i_clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none

module aspm_ana_group
	import aspm_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	input  wire logic [31:0] i_sel,
	input  wire logic [3:0]  i_dout,
	input  wire logic [3:0]  i_dir,
	input  wire logic [9:0]  i_pin_in,
	output logic      [9:0]  o_pin_out,
	output logic      [9:0]  o_pin_oe,
	output logic      [9:0]  o_ana_en,
	output logic      [3:0]  o_din
);

	typedef struct packed {
		logic [9:0] sync1;
		logic [9:0] sync2;
		logic [9:0] pin_out;
		logic [9:0] pin_oe;
		logic [9:0] ana_en;
	} aspm_ana_s;

	aspm_ana_s st_reg;
	aspm_ana_s st_next;

	// ----------------------------------------------------------------
	// routing
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.sync1 = i_pin_in;
		st_next.sync2 = st_reg.sync1;
		// pins without a digital bit stay analog whatever is written
		st_next.pin_out = '0;
		st_next.pin_oe  = '0;
		st_next.ana_en  = AG_ANA_RST;
		for (int b = 0; b < 4; b++) begin
			// only the four odd bits matter; even bits never read
			if (!i_sel[ASD_SEL_BIT[b]]) begin
				st_next.ana_en[ASD_PIN_IDX[b]]  = 1'b0;
				st_next.pin_out[ASD_PIN_IDX[b]] = i_dout[b];
				st_next.pin_oe[ASD_PIN_IDX[b]]  = i_dir[b];
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg.sync1   <= '0;
			st_reg.sync2   <= '0;
			st_reg.pin_out <= '0;
			st_reg.pin_oe  <= '0;
			st_reg.ana_en  <= AG_ANA_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_pin_out = st_reg.pin_out;
	assign o_pin_oe  = st_reg.pin_oe;
	assign o_ana_en  = st_reg.ana_en;

	// four digital bits, no pullup anywhere in this group
	for (genvar g = 0; g < 4; g++) begin : g_din
		assign o_din[g] = st_reg.sync2[ASD_PIN_IDX[g]];
	end

endmodule : aspm_ana_group

`default_nettype wire

// [verilog/aspm_pin_mux.sv]
/*
 * Analog-shared pin multiplexer: an eight-pin comparator-capable group
 * and two ten-pin analog groups, configured over classic Wishbone.
 * Assumes pins and comparator outputs are asynchronous to i_clk_sys and
 * that i_wb_ctrl_master is high while the control processor owns the bus.
 */
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - eight comparator-group pins: input, output, or one of six comparator outputs
// - pullup-disable bit at one turns that pin's pullup off
// - after reset every pin is analog with its digital function off; the comparator-group pullups come out of reset on (pullup-disable bits 0)
// - only the control processor may read or write these registers
// - two-bit field per pin: 00 mode 0 up to 11 mode 3
// - modes 1 and 2 connect nothing to the pin
// - mode 0 digital bit; mode 3 fixed comparator map, pins 128, 134 unused
// - eight readable, writable digital bits with per-bit direction
// - each analog group has four digital bits without pullups
// - first group: odd select bit zero is digital, one is analog
// - first group digital bits 2, 4, 6, 12 on A2, A4, A6, B4
// - even select bits of first group do not affect routing
// - second group: bits 18, 20, 22, 28 on A2, A4, A6, B4
// - even select bits of second group are ignored
// - analog groups: readable, writable digital bits with per-bit direction
// - unlisted table positions connect no function
module aspm_pin_mux
	import aspm_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic        i_wb_ctrl_master,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// comparator-capable group
	input  wire logic [5:0]  i_cmp_out,
	input  wire logic [7:0]  i_cg_pin_in,
	output logic      [7:0]  o_cg_pin_out,
	output logic      [7:0]  o_cg_pin_oe,
	output logic      [7:0]  o_cg_pullup_en,
	// first analog group
	input  wire logic [9:0]  i_ag1_pin_in,
	output logic      [9:0]  o_ag1_pin_out,
	output logic      [9:0]  o_ag1_pin_oe,
	output logic      [9:0]  o_ag1_ana_en,
	// second analog group
	input  wire logic [9:0]  i_ag2_pin_in,
	output logic      [9:0]  o_ag2_pin_out,
	output logic      [9:0]  o_ag2_pin_oe,
	output logic      [9:0]  o_ag2_ana_en
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [15:0] cmp_mode;
		logic [7:0]  cmp_pud;
		logic [7:0]  cmp_dout;
		logic [7:0]  cmp_dir;
		logic [31:0] ag1_sel;
		logic [3:0]  ag1_dout;
		logic [3:0]  ag1_dir;
		logic [31:0] ag2_sel;
		logic [3:0]  ag2_dout;
		logic [3:0]  ag2_dir;
		logic [7:0]  pin_sync1;
		logic [7:0]  pin_sync2;
		logic [5:0]  cmp_sync1;
		logic [5:0]  cmp_sync2;
		logic [7:0]  pin_out;
		logic [7:0]  pin_oe;
	} aspm_state_s;

	aspm_state_s st_reg;
	aspm_state_s st_next;

	logic [3:0] ag1_din;
	logic [3:0] ag2_din;

	// ----------------------------------------------------------------
	// byte-lane write merge
	// ----------------------------------------------------------------
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = old_v;
		for (int k = 0; k < 4; k++) begin
			if (sel[k]) begin
				res[8*k +: 8] = new_v[8*k +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case ({i_wb_adr[7:2], 2'b00})
			CMP_MODE_OFS: rd_mux[15:0] = st_reg.cmp_mode;
			CMP_PUD_OFS:  rd_mux[7:0]  = st_reg.cmp_pud;
			// data reads return the pin level, not the output latch
			CMP_DATA_OFS: rd_mux[7:0]  = st_reg.pin_sync2;
			CMP_DIR_OFS:  rd_mux[7:0]  = st_reg.cmp_dir;
			AG1_SEL_OFS:  rd_mux       = st_reg.ag1_sel;
			AG1_DATA_OFS: rd_mux[3:0]  = ag1_din;
			AG1_DIR_OFS:  rd_mux[3:0]  = st_reg.ag1_dir;
			AG2_SEL_OFS:  rd_mux       = st_reg.ag2_sel;
			AG2_DATA_OFS: rd_mux[3:0]  = ag2_din;
			AG2_DIR_OFS:  rd_mux[3:0]  = st_reg.ag2_dir;
			default:      rd_mux       = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        access;
		logic [31:0] wv;
		access = 1'b0;
		wv = 32'h0000_0000;

		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.pin_sync1 = i_cg_pin_in;
		st_next.pin_sync2 = st_reg.pin_sync1;
		st_next.cmp_sync1 = i_cmp_out;
		st_next.cmp_sync2 = st_reg.cmp_sync1;

		// one-wait-state slave: answer in the cycle after the request
		access = i_wb_cyc & i_wb_stb & ~st_reg.ack;
		if (access) begin
			st_next.ack = 1'b1;
			// other masters get an ack, zero data, and no effect
			st_next.rdata = 32'h0000_0000;
			if (i_wb_ctrl_master) begin
				if (!i_wb_we) begin
					st_next.rdata = rd_mux;
				end else begin
					case ({i_wb_adr[7:2], 2'b00})
						CMP_MODE_OFS: begin
							wv = lane_merge({16'h0000, st_reg.cmp_mode}, i_wb_dat, i_wb_sel);
							st_next.cmp_mode = wv[15:0];
						end
						CMP_PUD_OFS: begin
							wv = lane_merge({24'h00_0000, st_reg.cmp_pud}, i_wb_dat, i_wb_sel);
							st_next.cmp_pud = wv[7:0];
						end
						CMP_DATA_OFS: begin
							wv = lane_merge({24'h00_0000, st_reg.cmp_dout}, i_wb_dat, i_wb_sel);
							st_next.cmp_dout = wv[7:0];
						end
						CMP_DIR_OFS: begin
							wv = lane_merge({24'h00_0000, st_reg.cmp_dir}, i_wb_dat, i_wb_sel);
							st_next.cmp_dir = wv[7:0];
						end
						AG1_SEL_OFS: begin
							st_next.ag1_sel = lane_merge(st_reg.ag1_sel, i_wb_dat, i_wb_sel);
						end
						AG1_DATA_OFS: begin
							wv = lane_merge({28'h000_0000, st_reg.ag1_dout}, i_wb_dat, i_wb_sel);
							st_next.ag1_dout = wv[3:0];
						end
						AG1_DIR_OFS: begin
							wv = lane_merge({28'h000_0000, st_reg.ag1_dir}, i_wb_dat, i_wb_sel);
							st_next.ag1_dir = wv[3:0];
						end
						AG2_SEL_OFS: begin
							st_next.ag2_sel = lane_merge(st_reg.ag2_sel, i_wb_dat, i_wb_sel);
						end
						AG2_DATA_OFS: begin
							wv = lane_merge({28'h000_0000, st_reg.ag2_dout}, i_wb_dat, i_wb_sel);
							st_next.ag2_dout = wv[3:0];
						end
						AG2_DIR_OFS: begin
							wv = lane_merge({28'h000_0000, st_reg.ag2_dir}, i_wb_dat, i_wb_sel);
							st_next.ag2_dir = wv[3:0];
						end
						default: begin
							wv = 32'h0000_0000;
						end
					endcase
				end
			end
		end

		// comparator-capable pin routing
		for (int i = 0; i < 8; i++) begin
			st_next.pin_out[i] = 1'b0;
			st_next.pin_oe[i]  = 1'b0;
			case (aspm_mode_e'(st_reg.cmp_mode[2*i +: 2]))
				ASPM_MODE_GPIO: begin
					st_next.pin_out[i] = st_reg.cmp_dout[i];
					st_next.pin_oe[i]  = st_reg.cmp_dir[i];
				end
				ASPM_MODE_CMP: begin
					if (CMP_PIN_VALID[i]) begin
						st_next.pin_out[i] = st_reg.cmp_sync2[CMP_PIN_SRC[i]];
						st_next.pin_oe[i]  = 1'b1;
					end
				end
				default: begin
					// reserved modes: driver off, pin floats to analog
					st_next.pin_oe[i] = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg.ack       <= 1'b0;
			st_reg.rdata     <= 32'h0000_0000;
			st_reg.cmp_mode  <= CMP_MODE_RST;
			st_reg.cmp_pud   <= CMP_PUD_RST;
			st_reg.cmp_dout  <= CMP_DATA_RST;
			st_reg.cmp_dir   <= CMP_DIR_RST;
			st_reg.ag1_sel   <= AG_SEL_RST;
			st_reg.ag1_dout  <= AG_DATA_RST;
			st_reg.ag1_dir   <= AG_DIR_RST;
			st_reg.ag2_sel   <= AG_SEL_RST;
			st_reg.ag2_dout  <= AG_DATA_RST;
			st_reg.ag2_dir   <= AG_DIR_RST;
			st_reg.pin_sync1 <= 8'h00;
			st_reg.pin_sync2 <= 8'h00;
			st_reg.cmp_sync1 <= 6'h00;
			st_reg.cmp_sync2 <= 6'h00;
			st_reg.pin_out   <= 8'h00;
			st_reg.pin_oe    <= 8'h00;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// analog groups
	// ----------------------------------------------------------------
	// is left to software: both analog loads share the pin here
	aspm_ana_group u_ag1 (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_sel     (st_reg.ag1_sel),
		.i_dout    (st_reg.ag1_dout),
		.i_dir     (st_reg.ag1_dir),
		.i_pin_in  (i_ag1_pin_in),
		.o_pin_out (o_ag1_pin_out),
		.o_pin_oe  (o_ag1_pin_oe),
		.o_ana_en  (o_ag1_ana_en),
		.o_din     (ag1_din)
	);

	aspm_ana_group u_ag2 (
		.i_clk_sys (i_clk_sys),
		.i_arst_n  (i_arst_n),
		.i_sel     (st_reg.ag2_sel),
		.i_dout    (st_reg.ag2_dout),
		.i_dir     (st_reg.ag2_dir),
		.i_pin_in  (i_ag2_pin_in),
		.o_pin_out (o_ag2_pin_out),
		.o_pin_oe  (o_ag2_pin_oe),
		.o_ana_en  (o_ag2_ana_en),
		.o_din     (ag2_din)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_wb_ack       = st_reg.ack;
	assign o_wb_dat       = st_reg.rdata;
	assign o_cg_pin_out   = st_reg.pin_out;
	assign o_cg_pin_oe    = st_reg.pin_oe;
	assign o_cg_pullup_en = ~st_reg.cmp_pud;

endmodule : aspm_pin_mux

`default_nettype wire

// [verification/aspm_pin_mux_checker.sv]
/* assertions on the aspm_pin_mux ports: bus handshake and pad state
   assumes a bind from the bench top; one clock, async low reset */
`timescale 1ns/100ps
`default_nettype none
module aspm_pin_mux_checker (
	input wire logic        i_clk_sys,
	input wire logic        i_arst_n,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic        i_wb_ctrl_master,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic [7:0]  o_cg_pin_oe,
	input wire logic [9:0]  o_ag1_pin_out,
	input wire logic [9:0]  o_ag1_pin_oe,
	input wire logic [9:0]  o_ag1_ana_en,
	input wire logic [9:0]  o_ag2_pin_out,
	input wire logic [9:0]  o_ag2_pin_oe,
	input wire logic [9:0]  o_ag2_ana_en
);
	// pins without a digital bit, same in both groups
	localparam logic [9:0] ANA_ONLY = 10'h2E5;
	logic req;
	assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	// ----------
	// assertions
	// ----------
	a_ack_after_req: assert property (req |=> o_wb_ack)
		else $error("no ack after request");
	a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_ack_has_cause: assert property (o_wb_ack |-> $past(req))
		else $error("ack without request");
	a_foreign_read: assert property (req && !i_wb_we && !i_wb_ctrl_master
		|=> o_wb_dat == 32'h0000_0000) else $error("foreign read not zero");
	a_reset_analog: assert property ($rose(i_arst_n) |-> o_cg_pin_oe == 8'h00
		&& (o_ag1_ana_en & o_ag2_ana_en) == 10'h3FF
		&& (o_ag1_pin_oe | o_ag2_pin_oe) == 10'h000) else $error("not analog after reset");
	a_drive_by_bus: assert property ($changed({o_cg_pin_oe, o_ag1_pin_oe, o_ag2_pin_oe})
		|-> $past(o_wb_ack)) else $error("driver enable moved without bus write");
	a_no_overlap: assert property (((o_ag1_pin_oe | o_ag1_pin_out) & o_ag1_ana_en
		| (o_ag2_pin_oe | o_ag2_pin_out) & o_ag2_ana_en) == 10'h000)
		else $error("digital drive on analog pin");
	a_fixed_analog: assert property ((o_ag1_ana_en & o_ag2_ana_en & ANA_ONLY) == ANA_ONLY)
		else $error("analog-only pin lost analog path");
	c_write: cover property (req && i_wb_we);
	c_foreign: cover property (req && !i_wb_ctrl_master);
	c_ag2_drive: cover property ($rose(o_ag2_pin_oe[3]));
endmodule : aspm_pin_mux_checker
`default_nettype wire

// [verification/aspm_pin_env.sv]
/* pad and comparator model beside aspm_pin_mux: resolves pad levels
   assumes the bench gives external levels and comparator states */
`timescale 1ns/100ps
`default_nettype none
module aspm_pin_env (
	input  wire logic       i_clk_sys,
	input  wire logic [7:0] i_cg_out,
	input  wire logic [7:0] i_cg_oe,
	input  wire logic [7:0] i_cg_pull,
	input  wire logic [7:0] i_cg_drv,
	input  wire logic [7:0] i_cg_ext,
	input  wire logic [5:0] i_cmp_set,
	input  wire logic [9:0] i_ag1_out,
	input  wire logic [9:0] i_ag1_oe,
	input  wire logic [9:0] i_ag2_out,
	input  wire logic [9:0] i_ag2_oe,
	input  wire logic [9:0] i_ag_ext,
	output logic      [7:0] o_cg_pin,
	output logic      [5:0] o_cmp,
	output logic      [9:0] o_ag1_pin,
	output logic      [9:0] o_ag2_pin
);
	logic tgl = 1'b0;
	// a floating pad wanders so a stale value never reads as valid
	always @(posedge i_clk_sys) tgl <= ~tgl;
	assign o_cmp = i_cmp_set;
	// no pullup here: an external source holds undriven pads
	// one external source per pad: software enables a single analog load
	assign o_ag1_pin = (i_ag1_oe & i_ag1_out) | (~i_ag1_oe & i_ag_ext);
	assign o_ag2_pin = (i_ag2_oe & i_ag2_out) | (~i_ag2_oe & i_ag_ext);
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (i_cg_oe[i])
				o_cg_pin[i] = i_cg_out[i];
			else if (i_cg_drv[i])
				o_cg_pin[i] = i_cg_ext[i];
			else
				o_cg_pin[i] = i_cg_pull[i] | tgl;
		end
	end
endmodule : aspm_pin_env
`default_nettype wire

// [verification/aspm_pin_mux_tb_top.sv]
/* bench for aspm_pin_mux: wishbone tasks, one task per scenario
   assumes aspm_pin_env on the pad side and the checker bound below */
`timescale 1ns/100ps
`default_nettype none
module aspm_pin_mux_tb_top
	import aspm_pkg::*;
;
	logic        clk, ack, rst_n = 1'b0, ctrl = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0]  sel = 4'hF;
	logic [7:0]  adr = 8'h00, cg_ext = 8'h00, cg_drv = 8'h00;
	logic [7:0]  cg_out, cg_oe, cg_pu, cg_pin;
	logic [31:0] wdat = 32'h0000_0000, rdat, rd;
	logic [5:0]  cmp_set = 6'h00, cmp;
	logic [9:0]  a1_out, a1_oe, a1_ana, a1_pin, a2_out, a2_oe, a2_ana, a2_pin;
	logic [9:0]  ag_ext = 10'h3EF;
	int          n_fail = 0, num_checks = 0, cyc_cnt = 0;

	aspm_pin_mux aspm_pin_mux_inst (
		.i_clk_sys(clk), .i_arst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
		.i_wb_ctrl_master(ctrl), .o_wb_dat(rd), .o_wb_ack(ack), .i_cmp_out(cmp),
		.i_cg_pin_in(cg_pin), .o_cg_pin_out(cg_out), .o_cg_pin_oe(cg_oe),
		.o_cg_pullup_en(cg_pu), .i_ag1_pin_in(a1_pin), .o_ag1_pin_out(a1_out),
		.o_ag1_pin_oe(a1_oe), .o_ag1_ana_en(a1_ana), .i_ag2_pin_in(a2_pin),
		.o_ag2_pin_out(a2_out), .o_ag2_pin_oe(a2_oe), .o_ag2_ana_en(a2_ana)
	);
	aspm_pin_env aspm_pin_env_inst (
		.i_clk_sys(clk), .i_cg_out(cg_out), .i_cg_oe(cg_oe), .i_cg_pull(cg_pu),
		.i_cg_drv(cg_drv), .i_cg_ext(cg_ext), .i_cmp_set(cmp_set), .i_ag1_out(a1_out),
		.i_ag1_oe(a1_oe), .i_ag2_out(a2_out), .i_ag2_oe(a2_oe), .i_ag_ext(ag_ext),
		.o_cg_pin(cg_pin), .o_cmp(cmp), .o_ag1_pin(a1_pin), .o_ag2_pin(a2_pin)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			n_fail++;
			close_out();
		end
	end
	// -------------------
	// bus and check tasks
	// -------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// the wait has no bound of its own: the cycle ceiling above ends a hang
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		@(posedge clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
		do @(posedge clk); while (ack !== 1'b1);
		rdat = rd;
		{cyc, stb, we} <= 3'b000;
	endtask : wb
	task automatic settle();
		repeat (4) @(posedge clk);
	endtask : settle
	// ---------
	// scenarios
	// ---------
	task automatic t_reset();
		chk(cg_oe, 32'h0000_0000);
		chk({a2_ana, a1_ana}, 32'h000F_FFFF);
		chk(cg_pu, 32'h0000_00FF);
		wb(0, AG2_SEL_OFS, 32'h0000_0000);
		chk(rdat, AG_SEL_RST);
	endtask : t_reset
	task automatic t_access();
		ctrl <= 1'b0;
		wb(1, AG1_SEL_OFS, 32'h0000_0000);
		wb(0, AG1_SEL_OFS, 32'h0000_0000);
		chk(rdat, 32'h0000_0000);
		ctrl <= 1'b1;
		wb(0, AG1_SEL_OFS, 32'h0000_0000);
		chk(rdat, 32'hAAAA_AAAA);
		wb(1, AG1_SEL_OFS, 32'h0000_0000, 4'h1);
		wb(0, AG1_SEL_OFS, 32'h0000_0000);
		chk(rdat, 32'hAAAA_AA00);
		wb(0, 8'h40, 32'h0000_0000);
		chk(rdat, 32'h0000_0000);
	endtask : t_access
	task automatic t_cg();
		wb(1, CMP_DIR_OFS, 32'h0000_00FF);
		wb(1, CMP_DATA_OFS, 32'h0000_00A5);
		for (int m = 0; m < 4; m++) begin
			wb(1, CMP_MODE_OFS, {16'h0000, {8{m[1:0]}}});
			settle();
			chk(cg_oe, m == 0 ? 8'hFF : m == 3 ? 8'hBE : 8'h00);
			if (m == 0)
				chk(cg_out, 32'h0000_00A5);
		end
		// comparator n sits on bit n-1; expected pin images worked by hand
		for (int k = 0; k < 2; k++) begin
			cmp_set <= k ? 6'h12 : 6'h2D;
			settle();
			chk(cg_out, k ? 8'h88 : 8'h36);
		end
		wb(1, CMP_MODE_OFS, 32'h0000_5575);
		settle();
		chk(cg_oe, 32'h0000_0004);
		wb(1, CMP_MODE_OFS, 32'h0000_0000);
		wb(1, CMP_DIR_OFS, 32'h0000_0000);
		{cg_drv, cg_ext} <= 16'hFF3C;
		settle();
		wb(0, CMP_DATA_OFS, 32'h0000_0000);
		chk(rdat, 32'h0000_003C);
		cg_drv <= 8'h00;
		wb(1, CMP_PUD_OFS, 32'h0000_000F);
		settle();
		chk(cg_pu, 32'h0000_00F0);
		wb(0, CMP_DATA_OFS, 32'h0000_0000);
		chk(rdat & 32'h0000_00F0, 32'h0000_00F0);
	endtask : t_cg
	task automatic t_ag(input logic g);
		logic [7:0] o;
		o = g ? 8'h0C : 8'h00;
		wb(1, AG1_DIR_OFS + o, 32'h0000_000F);
		wb(1, AG1_DATA_OFS + o, 32'h0000_000A);
		wb(1, AG1_SEL_OFS + o, 32'h5555_5555);
		settle();
		chk(g ? a2_oe : a1_oe, 32'h0000_011A);
		chk(g ? a2_out : a1_out, 32'h0000_0108);
		chk(g ? a2_ana : a1_ana, 32'h0000_02E5);
		for (int k = 0; k < 4; k++) begin
			wb(1, AG1_SEL_OFS + o, ~(32'h1 << (k == 3 ? 25 : 5 + 4 * k)));
			settle();
			chk(g ? a2_oe : a1_oe, 10'h001 << (k == 0 ? 1 : k == 3 ? 8 : k + 2));
		end
		wb(1, AG1_DIR_OFS + o, 32'h0000_0000);
		wb(1, AG1_SEL_OFS + o, 32'h5555_5555);
		settle();
		wb(0, AG1_DATA_OFS + o, 32'h0000_0000);
		chk(rdat, 32'h0000_000B);
		wb(1, AG1_SEL_OFS + o, AG_SEL_RST);
		settle();
		chk(g ? a2_ana : a1_ana, 32'h0000_03FF);
	endtask : t_ag

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_access();
		t_cg();
		t_ag(1'b0);
		t_ag(1'b1);
		close_out();
	end
endmodule : aspm_pin_mux_tb_top

bind aspm_pin_mux aspm_pin_mux_checker aspm_pin_mux_checker_inst (
	.i_clk_sys, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_ctrl_master, .o_wb_dat,
	.o_wb_ack, .o_cg_pin_oe, .o_ag1_pin_out, .o_ag1_pin_oe, .o_ag1_ana_en, .o_ag2_pin_out,
	.o_ag2_pin_oe, .o_ag2_ana_en
);
`default_nettype wire
